// ---- verilog/alpd_top.sv ----
`timescale 1ns/1ns
`include "alpd_defines.svh"
module alpd_top
  import alpd_pkg::*;
#(
  parameter int unsigned WINDOW_CYCLES = `ALPD_WINDOW_CYCLES,
  parameter int unsigned RAMP_STEP0 = `ALPD_RAMP_STEP(`ALPD_RAMP0_MS),
  parameter int unsigned RAMP_STEP1 = `ALPD_RAMP_STEP(`ALPD_RAMP1_MS),
  parameter int unsigned RAMP_STEP2 = `ALPD_RAMP_STEP(`ALPD_RAMP2_MS),
  parameter int unsigned RAMP_STEP3 = `ALPD_RAMP_STEP(`ALPD_RAMP3_MS)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic light_sensor_in,
  input wire logic duty_cycle_in,
  output logic sensor_supply_out,
  output logic [6:0] string_drive,
  output logic boost_fixed_level
);
  // ****************************************
  // functions
  // ****************************************
  function automatic logic [9:0] curve(input logic [9:0] x,
      input logic [9:0] b1, input logic [9:0] b2,
      input logic [7:0] s0, input logic [7:0] s1, input logic [7:0] s2);
    logic [19:0] y1;
    logic [19:0] y2;
    logic [19:0] y;
    y1 = (20'(b1) * 20'(s0)) >> 4;
    y2 = y1 + ((20'(b2 - b1) * 20'(s1)) >> 4);
    if (x < b1) begin
      y = (20'(x) * 20'(s0)) >> 4;
    end else if (x < b2) begin
      y = y1 + ((20'(x - b1) * 20'(s1)) >> 4);
    end else begin
      y = y2 + ((20'(x - b2) * 20'(s2)) >> 4);
    end
    return (y > 20'(`ALPD_DUTY_MAX)) ? `ALPD_DUTY_MAX : y[9:0];
  endfunction

  // full scale on either side passes the other through unchanged
  function automatic logic [9:0] mul10(input logic [9:0] a,
      input logic [9:0] b);
    logic [19:0] p;
    p = 20'(a) * 20'(b);
    if (a == `ALPD_DUTY_MAX) begin
      return b;
    end
    if (b == `ALPD_DUTY_MAX) begin
      return a;
    end
    return p[19:10];
  endfunction

  function automatic logic [19:0] base_period(input logic [2:0] s);
    unique case (s)
      3'h0: return 20'(`ALPD_CLK_HZ / 992);
      3'h1: return 20'(`ALPD_CLK_HZ / 1526);
      3'h2: return 20'(`ALPD_CLK_HZ / 1983);
      3'h3: return 20'(`ALPD_CLK_HZ / 2441);
      3'h4: return 20'(`ALPD_CLK_HZ / 2974);
      3'h5: return 20'(`ALPD_CLK_HZ / 3965);
      3'h6: return 20'(`ALPD_CLK_HZ / 4883);
      3'h7: return 20'(`ALPD_CLK_HZ / 19531);
    endcase
  endfunction

  function automatic logic [19:0] out_period(input logic [4:0] c);
    unique case (c)
      5'h00: return 20'(`ALPD_CLK_HZ / 229);
      5'h01: return 20'(`ALPD_CLK_HZ / 305);
      5'h02: return 20'(`ALPD_CLK_HZ / 381);
      5'h03: return 20'(`ALPD_CLK_HZ / 458);
      5'h04: return 20'(`ALPD_CLK_HZ / 534);
      5'h05: return 20'(`ALPD_CLK_HZ / 610);
      5'h06: return 20'(`ALPD_CLK_HZ / 687);
      5'h07: return 20'(`ALPD_CLK_HZ / 763);
      5'h08: return 20'(`ALPD_CLK_HZ / 839);
      5'h09: return 20'(`ALPD_CLK_HZ / 916);
      5'h0A: return 20'(`ALPD_CLK_HZ / 992);
      5'h0B: return 20'(`ALPD_CLK_HZ / 1068);
      5'h0C: return 20'(`ALPD_CLK_HZ / 1144);
      5'h0D: return 20'(`ALPD_CLK_HZ / 1221);
      5'h0E: return 20'(`ALPD_CLK_HZ / 1297);
      5'h0F: return 20'(`ALPD_CLK_HZ / 1373);
      5'h10: return 20'(`ALPD_CLK_HZ / 1450);
      5'h11: return 20'(`ALPD_CLK_HZ / 1526);
      5'h12: return 20'(`ALPD_CLK_HZ / 1602);
      5'h13: return 20'(`ALPD_CLK_HZ / 1678);
      5'h14: return 20'(`ALPD_CLK_HZ / 1755);
      5'h15: return 20'(`ALPD_CLK_HZ / 1831);
      5'h16: return 20'(`ALPD_CLK_HZ / 1908);
      5'h17: return 20'(`ALPD_CLK_HZ / 1983);
      5'h18: return 20'(`ALPD_CLK_HZ / 2060);
      5'h19: return 20'(`ALPD_CLK_HZ / 2671);
      5'h1A: return 20'(`ALPD_CLK_HZ / 3203);
      5'h1B: return 20'(`ALPD_CLK_HZ / 3737);
      5'h1C: return 20'(`ALPD_CLK_HZ / 4270);
      5'h1D: return 20'(`ALPD_CLK_HZ / 4808);
      5'h1E: return 20'(`ALPD_CLK_HZ / 9766);
      5'h1F: return 20'(`ALPD_CLK_HZ / 19531);
    endcase
  endfunction

  function automatic logic phase_on(input logic [19:0] pc,
      input logic [10:0] duty, input logic [19:0] per);
    return {1'b0, pc, 10'h000} < (31'(duty) * 31'(per));
  endfunction

  // ****************************************
  // registers and bus slave
  // ****************************************
  alpd_ctrl_type ctrl_q;
  alpd_bus_state_type bus_q;
  logic [7:0] bright_q;
  logic [4:0] freq_q;
  logic [9:0] presc_q;
  logic [9:0] bp1_q;
  logic [9:0] bp2_q;
  logic [7:0] sl0_q;
  logic [7:0] sl1_q;
  logic [7:0] sl2_q;
  logic [9:0] light_q;
  logic [7:0] light_lo_q;
  logic [9:0] cur_q;
  logic [2:0] pos_q;
  logic [31:0] rd_d;
  logic req;
  logic acc_wr;
  logic acc_rd;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & (bus_q == ALPD_BUS_IDLE);
  assign acc_wr = avs_write & (bus_q == ALPD_BUS_ACK);
  assign acc_rd = avs_read & (bus_q == ALPD_BUS_ACK);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= ALPD_BUS_IDLE;
    end else begin
      unique case (bus_q)
        ALPD_BUS_IDLE: bus_q <= req ? ALPD_BUS_ACK : ALPD_BUS_IDLE;
        ALPD_BUS_ACK: bus_q <= ALPD_BUS_IDLE;
      endcase
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    case (avs_address)
      `ALPD_OFF_CTRL: rd_d = {20'h00000, ctrl_q};
      `ALPD_OFF_BRIGHT: rd_d = {24'h000000, bright_q};
      `ALPD_OFF_FREQ: rd_d = {27'h0000000, freq_q};
      `ALPD_OFF_PRESC: rd_d = {22'h000000, presc_q};
      `ALPD_OFF_CURVE_BP: rd_d = {6'h00, bp2_q, 6'h00, bp1_q};
      `ALPD_OFF_CURVE_SL: rd_d = {8'h00, sl2_q, sl1_q, sl0_q};
      `ALPD_OFF_LIGHT_HI: rd_d = {30'h00000000, light_q[9:8]};
      `ALPD_OFF_LIGHT_LO: rd_d = {24'h000000, light_lo_q};
      `ALPD_OFF_STATUS: rd_d = {11'h000, boost_fixed_level, 1'b0, pos_q,
                                6'h00, cur_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && bus_q == ALPD_BUS_IDLE) begin
      avs_readdata <= rd_d;
    end
  end

  // low half frozen when the high half is read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      light_lo_q <= 8'h00;
    end else if (acc_rd && avs_address == `ALPD_OFF_LIGHT_HI) begin
      light_lo_q <= light_q[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= alpd_ctrl_type'(`ALPD_CTRL_RESET);
      bright_q <= `ALPD_BRIGHT_RESET;
      freq_q <= `ALPD_FREQ_RESET;
      presc_q <= `ALPD_PRESC_RESET;
      bp1_q <= `ALPD_BP1_RESET;
      bp2_q <= `ALPD_BP2_RESET;
      sl0_q <= `ALPD_SLOPE_RESET;
      sl1_q <= `ALPD_SLOPE_RESET;
      sl2_q <= `ALPD_SLOPE_RESET;
    end else if (acc_wr) begin
      case (avs_address)
        `ALPD_OFF_CTRL: ctrl_q <= alpd_ctrl_type'(avs_writedata[11:0]);
        `ALPD_OFF_BRIGHT: bright_q <= avs_writedata[7:0];
        `ALPD_OFF_FREQ: freq_q <= avs_writedata[4:0];
        `ALPD_OFF_PRESC: presc_q <= avs_writedata[9:0];
        `ALPD_OFF_CURVE_BP: begin
          bp1_q <= avs_writedata[9:0];
          bp2_q <= avs_writedata[25:16];
        end
        `ALPD_OFF_CURVE_SL: begin
          sl0_q <= avs_writedata[7:0];
          sl1_q <= avs_writedata[15:8];
          sl2_q <= avs_writedata[23:16];
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] sens_s_q;
  logic [1:0] pin_s_q;
  logic sens_rise;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sens_s_q <= 3'h0;
      pin_s_q <= 2'h0;
    end else begin
      sens_s_q <= {sens_s_q[1:0], light_sensor_in};
      pin_s_q <= {pin_s_q[0], duty_cycle_in};
    end
  end
  assign sens_rise = sens_s_q[1] & ~sens_s_q[2];

  // ****************************************
  // light measurement
  // ****************************************
  logic [31:0] win_q;
  logic [9:0] pre_q;
  logic [9:0] acc_q;
  logic [9:0] presc_eff;
  logic win_end;

  assign presc_eff = (presc_q == 10'h000) ? 10'h001 : presc_q;
  assign win_end = (win_q == WINDOW_CYCLES - 1);

  // dividing by counting edges per prescale avoids a real divider
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= 32'h0000_0000;
      pre_q <= 10'h000;
      acc_q <= 10'h000;
      light_q <= 10'h000;
      sensor_supply_out <= 1'b0;
    end else begin
      sensor_supply_out <= ctrl_q.sensor_power_enable;
      if (!ctrl_q.sensor_power_enable) begin
        win_q <= 32'h0000_0000;
        pre_q <= 10'h000;
        acc_q <= 10'h000;
      end else if (win_end) begin
        win_q <= 32'h0000_0000;
        pre_q <= 10'h000;
        acc_q <= 10'h000;
        light_q <= acc_q;
      end else begin
        win_q <= win_q + 32'h0000_0001;
        if (sens_rise && pre_q >= presc_eff - 10'h001) begin
          pre_q <= 10'h000;
          if (acc_q != `ALPD_DUTY_MAX) begin
            acc_q <= acc_q + 10'h001;
          end
        end else if (sens_rise) begin
          pre_q <= pre_q + 10'h001;
        end
      end
    end
  end

  // ****************************************
  // duty source and target
  // ****************************************
  logic [19:0] dm_cnt_q;
  logic [19:0] dm_hi_q;
  logic [9:0] pin_duty_q;
  logic [9:0] led_duty;
  logic [9:0] light_duty;
  logic [9:0] target;
  logic direct;

  // fixed window of 2^20 cycles covers the slowest input period
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dm_cnt_q <= 20'h00000;
      dm_hi_q <= 20'h00000;
      pin_duty_q <= 10'h000;
    end else begin
      dm_cnt_q <= dm_cnt_q + 20'h00001;
      if (dm_cnt_q == `ALPD_DUTY_WIN_LAST) begin
        dm_hi_q <= 20'h00000;
        pin_duty_q <= dm_hi_q[19:10];
      end else if (pin_s_q[1]) begin
        dm_hi_q <= dm_hi_q + 20'h00001;
      end
    end
  end

  assign direct = ctrl_q.duty_source_mode_bit & ctrl_q.duty_source_select;
  assign light_duty = curve(light_q, bp1_q, bp2_q, sl0_q, sl1_q, sl2_q);

  always_comb begin
    logic [9:0] bd;
    bd = curve({bright_q, 2'b00}, bp1_q, bp2_q, sl0_q, sl1_q, sl2_q);
    unique case ({ctrl_q.duty_source_mode_bit, ctrl_q.duty_source_select})
      2'b01: led_duty = pin_duty_q;
      2'b10: led_duty = bd;
      2'b00: led_duty = mul10(pin_duty_q, bd);
      2'b11: led_duty = pin_duty_q;
    endcase
    if (ctrl_q.internal_light_calc_enable) begin
      target = mul10(led_duty, light_duty);
    end else begin
      target = led_duty;
    end
  end

  // ****************************************
  // slope smoother
  // ****************************************
  logic [31:0] st_q;
  logic [31:0] step_lim;

  always_comb begin
    unique case (ctrl_q.ramp_time_select)
      2'b00: step_lim = RAMP_STEP0;
      2'b01: step_lim = RAMP_STEP1;
      2'b10: step_lim = RAMP_STEP2;
      2'b11: step_lim = RAMP_STEP3;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= 32'h0000_0000;
      cur_q <= 10'h000;
    end else if (st_q >= step_lim - 32'h0000_0001) begin
      st_q <= 32'h0000_0000;
      if (cur_q < target) begin
        cur_q <= cur_q + 10'h001;
      end else if (cur_q > target) begin
        cur_q <= cur_q - 10'h001;
      end
    end else begin
      st_q <= st_q + 32'h0000_0001;
    end
  end

  // ****************************************
  // phase-rotated dimming engine
  // ****************************************
  logic [2:0] n_str;
  logic rot_on;
  logic [19:0] per;
  logic [19:0] pc_q;
  logic per_end;
  logic [3:0] rr_q;
  logic [3:0] rr_lim;
  logic [9:0] dl_q;
  logic [10:0] d11;
  logic [13:0] dn;
  logic part_on;
  logic all_on;
  logic [6:0] drive_d;
  logic adv;

  assign n_str = `ALPD_MIN_STRINGS + {1'b0, ctrl_q.string_count_select};
  assign rot_on = !ctrl_q.phase_rotation_off && !direct;
  assign rr_lim = 4'((4'h1 << ctrl_q.rotation_rate_select) - 4'h1);

  always_comb begin
    logic [19:0] op;
    op = out_period(freq_q);
    if (!ctrl_q.rotation_scheme_select) begin
      per = base_period(freq_q[4:2]);
      if (rot_on) begin
        per = 20'(per << freq_q[1:0]);
      end
    end else if (!rot_on) begin
      per = op;
    end else begin
      unique case (n_str)
        3'h4: per = op >> 2;
        3'h5: per = op / 20'h00005;
        3'h6: per = op / 20'h00006;
        3'h7: per = op / 20'h00007;
        default: per = op;
      endcase
    end
  end

  assign per_end = (pc_q >= per - 20'h00001);
  assign adv = per_end && rot_on && (rr_q >= rr_lim);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= 20'h00000;
    end else if (per_end) begin
      pc_q <= 20'h00000;
    end else begin
      pc_q <= pc_q + 20'h00001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rr_q <= 4'h0;
      pos_q <= 3'h0;
      dl_q <= 10'h000;
    end else if (per_end && !rot_on) begin
      rr_q <= 4'h0;
      pos_q <= 3'h0;
      dl_q <= cur_q;
    end else if (adv) begin
      rr_q <= 4'h0;
      if (pos_q >= n_str - 3'h1) begin
        pos_q <= 3'h0;
        dl_q <= cur_q;
      end else begin
        pos_q <= pos_q + 3'h1;
      end
    end else if (per_end) begin
      rr_q <= rr_q + 4'h1;
    end
  end

  assign d11 = (dl_q == `ALPD_DUTY_MAX) ? `ALPD_FULL_DUTY : {1'b0, dl_q};
  assign dn = 14'(d11 * 11'(n_str));
  assign part_on = phase_on(pc_q, {1'b0, dn[9:0]}, per);
  assign all_on = phase_on(pc_q, d11, per);

  always_comb begin
    logic [3:0] rk;
    drive_d = 7'h00;
    rk = 4'h0;
    for (int i = 0; i < 7; i++) begin
      rk = (3'(i) >= pos_q) ? 4'(3'(i) - pos_q)
                            : 4'(3'(i) + n_str - pos_q);
      if (3'(i) >= n_str) begin
        drive_d[i] = 1'b0;
      end else if (direct) begin
        drive_d[i] = pin_s_q[1];
      end else if (!rot_on) begin
        drive_d[i] = all_on;
      end else begin
        drive_d[i] = (rk < dn[13:10]) ||
                     (rk == dn[13:10] && part_on);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      string_drive <= 7'h00;
      boost_fixed_level <= 1'b0;
    end else begin
      string_drive <= drive_d;
      boost_fixed_level <= rot_on && (ctrl_q.rotation_scheme_select ?
          freq_q == `ALPD_TOP_CODE_S1 : freq_q == `ALPD_TOP_CODE_S0);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence bus_wait_s;
    req && avs_waitrequest ##1 req && !avs_waitrequest;
  endsequence

  bus_wait_a: assert property (req && bus_q == ALPD_BUS_IDLE |->
    bus_wait_s) else $error("bus answer not after one wait cycle");
  supply_pin_a: assert property ($rose(ctrl_q.sensor_power_enable) |=>
    sensor_supply_out) else $error("supply pin not raised");
  light_upd_a: assert property ($changed(light_q) |->
    $past(win_end) && $past(ctrl_q.sensor_power_enable))
    else $error("light result changed outside window end");
  calc_off_a: assert property (!ctrl_q.internal_light_calc_enable |->
    target == led_duty) else $error("light result applied while off");
  ramp_step_a: assert property ($changed(cur_q) |->
    (cur_q == $past(cur_q) + 10'h001) || (cur_q == $past(cur_q) - 10'h001))
    else $error("brightness stepped more than one");
  pass_thru_a: assert property ($past(direct) && direct &&
    $stable(n_str) |-> string_drive == ($past(drive_d)))
    else $error("pass-through output mismatch");
  unused_off_a: assert property ($stable(n_str) |=>
    (string_drive >> n_str) == 7'h00) else $error("unused string driven");
  rot_step_a: assert property (adv && pos_q < n_str - 3'h1 |=>
    pos_q == $past(pos_q) + 3'h1) else $error("rotation did not step");
  target_wrap_a: assert property ($changed(dl_q) |->
    $past(per_end) && ($past(pos_q) == 3'h0 || !rot_on || $past(adv)))
    else $error("target applied off boundary");
  boost_top_a: assert property (ctrl_q.phase_rotation_off |=>
    !boost_fixed_level) else $error("boost fixed without rotation");
endmodule // alpd_top

// ---- verilog/alpd_defines.svh ----
// Behaviour
// - sensor enable bit drives supply pin high and enables frequency counting.
// - count sensor edges for 500 ms, divide by 10-bit prescaler, 10-bit result.
// - calc enable low leaves the light result to the host only.
// - calc enable high lets light result steer brightness except pass-through.
// - light result mapped to duty through a three-segment linear curve.
// - light duty multiplies the duty from register, pin, or both.
// - ramp time select gives 130 ms, 0.5 s, 1.0 s or 2 s slopes.
// - slope smoothing also applies to register and pin brightness changes.
// - without sensor use, supply pin is a plain output following enable bit.
// - N strings, each one 1/N; some fully on plus one partial.
// - on/partial pattern walks through all active strings in turn.
// - rotation rate equals base rate or a lower rate by 2-bit select.
// - at the 19.5 kHz top rate with phase rotation on, boost holds a fixed level.
// - phase rotation on by default, off when its off bit is one.
// - scheme bit picks between two sets of base, shift, output rates.
// - scheme 0: upper code bits pick base rate, lower bits divide 1-8.
// - scheme 1: code picks output rate, shift rate is output times N.
// - pass-through mode ignores light result and phase rotation.
// - string count select gives 4 to 7 strings, used from the first.
`ifndef ALPD_DEFINES_SVH
`define ALPD_DEFINES_SVH
`define ALPD_CLK_HZ 50000000
`define ALPD_WINDOW_MS 500
`define ALPD_WINDOW_CYCLES (`ALPD_WINDOW_MS * (`ALPD_CLK_HZ / 1000))
`define ALPD_RAMP_STEPS 1024
`define ALPD_RAMP0_MS 130
`define ALPD_RAMP1_MS 500
`define ALPD_RAMP2_MS 1000
`define ALPD_RAMP3_MS 2000
`define ALPD_RAMP_STEP(ms) ((ms) * (`ALPD_CLK_HZ / 1000) / `ALPD_RAMP_STEPS)
`define ALPD_OFF_CTRL 6'h00
`define ALPD_OFF_BRIGHT 6'h04
`define ALPD_OFF_FREQ 6'h08
`define ALPD_OFF_PRESC 6'h0C
`define ALPD_OFF_CURVE_BP 6'h10
`define ALPD_OFF_CURVE_SL 6'h14
`define ALPD_OFF_LIGHT_HI 6'h18
`define ALPD_OFF_LIGHT_LO 6'h1C
`define ALPD_OFF_STATUS 6'h20
`define ALPD_CTRL_RESET 12'h208
`define ALPD_BRIGHT_RESET 8'hFF
`define ALPD_FREQ_RESET 5'h00
`define ALPD_PRESC_RESET 10'h001
`define ALPD_BP1_RESET 10'h100
`define ALPD_BP2_RESET 10'h300
`define ALPD_SLOPE_RESET 8'h10
`define ALPD_MIN_STRINGS 3'h4
`define ALPD_FULL_DUTY 11'h400
`define ALPD_DUTY_MAX 10'h3FF
`define ALPD_DUTY_WIN_LAST 20'hFFFFF
`define ALPD_TOP_CODE_S0 5'h1C
`define ALPD_TOP_CODE_S1 5'h1F
`endif

// ---- verilog/alpd_pkg.sv ----
package alpd_pkg;
  typedef struct packed {
    logic [1:0] rotation_rate_select;
    logic [1:0] string_count_select;
    logic [1:0] ramp_time_select;
    logic rotation_scheme_select;
    logic phase_rotation_off;
    logic duty_source_select;
    logic duty_source_mode_bit;
    logic internal_light_calc_enable;
    logic sensor_power_enable;
  } alpd_ctrl_type;
  typedef enum logic {
    ALPD_BUS_IDLE = 1'b0,
    ALPD_BUS_ACK = 1'b1
  } alpd_bus_state_type;
endpackage

// ---- tb/alpd_sensor_model.sv ----
`timescale 1ns/1ns
// ****************************************
// light sensor with frequency output
// ****************************************
module alpd_sensor_model #(
  parameter int HALF = 2
) (
  input wire logic mclk,
  input wire logic powered,
  output logic freq_out
);
  logic out_q = 1'b0;
  int cnt_q = 0;
  // unpowered pin is undefined: toggle each cycle so nothing relies on it
  always @(posedge mclk) begin
    if (powered) begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      if (cnt_q == HALF - 1) begin
        out_q <= ~out_q;
      end
    end else begin
      out_q <= ~out_q;
      cnt_q <= 0;
    end
  end
  assign freq_out = out_q;
endmodule // alpd_sensor_model

// ---- tb/ambient_light_phase_shift_dimming_tb.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module ambient_light_phase_shift_dimming_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic duty_cycle_in = 1'b0;
  logic light_sensor_in, sensor_supply_out, boost_fixed_level;
  logic [6:0] string_drive;
  logic [6:0] seen;
  logic [31:0] rd;
  int num_errors = 0;
  int n_compared = 0;
  int presc, n, b, d, pc, full, bad;
  logic [5:0] ra [7] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h3C};
  logic [31:0] rv [7] = '{32'h208, 32'hFF, 32'h0, 32'h1, 32'h3000100,
    32'h101010, 32'h0};
  logic [11:0] bc [5] = '{12'h004, 12'h014, 12'h024, 12'h024, 12'h004};
  logic [4:0] bf [5] = '{5'h1C, 5'h1C, 5'h1C, 5'h1F, 5'h1F};
  logic be [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  always #10 mclk = ~mclk;

  alpd_top #(.WINDOW_CYCLES(200), .RAMP_STEP0(2), .RAMP_STEP1(3),
    .RAMP_STEP2(4), .RAMP_STEP3(5)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .light_sensor_in(light_sensor_in),
    .duty_cycle_in(duty_cycle_in), .sensor_supply_out(sensor_supply_out),
    .string_drive(string_drive), .boost_fixed_level(boost_fixed_level));

  alpd_sensor_model i_sensor (.mclk(mclk),
    .powered(sensor_supply_out), .freq_out(light_sensor_in));

  // ****************************************
  // bus master and closing
  // ****************************************
  task automatic bus(input logic we, input logic [5:0] a,
    input logic [31:0] wd, output logic [31:0] r);
    int k;
    logic w;
    k = 0;
    w = 1'b1;
    r = 32'h0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= wd;
    // settled mid-cycle values equal what the next rising edge samples
    do begin
      @(negedge mclk);
      w = avs_waitrequest;
      r = avs_readdata;
      @(posedge mclk);
      k++;
    end while (w !== 1'b0 && k < 50);
    if (k >= 50) num_errors++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic stop_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    #1600000;
    num_errors++;
    stop_test();
  end

  initial begin
    void'($urandom(37));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    bus(1'b1, 6'h3C, 32'hFFFFFFFF, rd);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, ra[i], 32'h0, rd);
      `CHK(rd, rv[i])
    end
    // sensor pattern has 4-cycle period: 50 edges per 200-cycle window
    presc = $urandom_range(7, 0);
    bus(1'b1, 6'h0C, 32'(presc), rd);
    bus(1'b1, 6'h00, 32'h209, rd);
    repeat (3) @(posedge mclk);
    `CHK(sensor_supply_out, 1'b1)
    repeat (500) @(posedge mclk);
    n = 50 / ((presc == 0) ? 1 : presc);
    bus(1'b0, 6'h18, 32'h0, rd);
    `CHK(rd, 32'(n >> 8))
    bus(1'b0, 6'h1C, 32'h0, rd);
    `CHK(rd, 32'(n & 255))
    bus(1'b1, 6'h00, 32'h208, rd);
    repeat (3) @(posedge mclk);
    `CHK(sensor_supply_out, 1'b0)
    n = $urandom_range(3, 0);
    bus(1'b1, 6'h00, 32'h00C | (32'(n) << 8), rd);
    duty_cycle_in <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK(string_drive, 7'((1 << (n + 4)) - 1))
    duty_cycle_in <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK(string_drive, 7'h00)
    // brightness mode at top rate; slopes of 16/16 give duty = 4 * level
    b = $urandom_range(240, 64);
    d = b * 4;
    bus(1'b1, 6'h08, 32'h1C, rd);
    bus(1'b1, 6'h04, 32'(b), rd);
    bus(1'b1, 6'h00, 32'h004 | (32'(n) << 8), rd);
    n = n + 4;
    repeat (2 * n * 2560 + 2400) @(posedge mclk);
    bus(1'b0, 6'h20, 32'h0, rd);
    `CHK(rd[9:0], 10'(d))
    full = d * n / 1024;
    seen = 7'h00;
    bad = 0;
    repeat (n * 2560) begin
      @(posedge mclk);
      pc = $countones(string_drive);
      if (pc != full && pc != full + 1) bad++;
      seen = seen | string_drive;
    end
    `CHK(bad, 0)
    `CHK(seen, 7'((1 << n) - 1))
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 6'h08, 32'(bf[i]), rd);
      bus(1'b1, 6'h00, 32'(bc[i]), rd);
      repeat (4) @(posedge mclk);
      `CHK(boost_fixed_level, be[i])
    end
    stop_test();
  end
endmodule // ambient_light_phase_shift_dimming_tb
